/* File: logic/fpd_top.sv */
// two-channel fan duty control: configuration, duty derivation, ramp and pwm
`timescale 1ns/1ns
`include "fpd_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - standby bit halts conversions and pwm drive
// - writing soft reset bit restores all registers
// - timeout bit low enables bus timeout
// - fan one polarity bit sets full-duty level
// - fan two polarity bit sets full-duty level
// - below start temperature duty zero, then start
// - hold bit keeps start duty below threshold
// - source bit picks die or thermistor two
// - spin-up disable bit skips spin-up
// - start duty codes above 240 mean full
// - ceiling caps duty, codes above 240 full
// - manual mode ignores the ceiling register
// - automatic mode keeps writing computed goal duty
// - nonzero rate ramps toward goal gradually
// - present duty register shows driven duty
// - ramp steps two, interval doubles per code
// - unassigned fan follows goal, clipped at 240
// - fastest frequency truncates duty to fours
////////////////////////////////////////////////////////////////////////////////
module fpd_top import fpd_pkg::*; #(
  parameter int TICK_CYCLES = `FPD_CLK_HZ / 1000000 * `FPD_TICK_US,
  parameter int SLOT_20 = `FPD_CLK_HZ / (`FPD_FREQ_20 * `FPD_SLOTS),
  parameter int SLOT_33 = `FPD_CLK_HZ / (`FPD_FREQ_33 * `FPD_SLOTS),
  parameter int SLOT_50 = `FPD_CLK_HZ / (`FPD_FREQ_50 * `FPD_SLOTS),
  parameter int SLOT_100 = `FPD_CLK_HZ / (`FPD_FREQ_100 * `FPD_SLOTS),
  parameter int SLOT_35K = `FPD_CLK_HZ / (`FPD_FREQ_35K * `FPD_SLOTS)
) (
  input logic CLK,
  input logic RST,
  input logic REG_WR,
  input logic [7:0] REG_ADDR,
  input logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input logic [7:0] TEMP_CH1,
  input logic [7:0] TEMP_CH2,
  input logic [7:0] START_TEMP_CH1,
  input logic [7:0] START_TEMP_CH2,
  input logic TEMP_STEP_TWO,
  input fpd_fan_ctl_t [1:0] FAN_CTL,
  input logic [2:0] FREQ_SEL,
  output logic CONVERT_HALT,
  output logic BUS_TIMEOUT_EN,
  output logic TEMP2_SRC_DIE,
  output logic SPINUP_EN,
  input logic FAN_ONE_DRIVE_OUTPUT_I,
  output logic FAN_ONE_DRIVE_OUTPUT_O,
  output logic FAN_ONE_DRIVE_OUTPUT_OE,
  input logic FAN_TWO_DRIVE_OUTPUT_I,
  output logic FAN_TWO_DRIVE_OUTPUT_O,
  output logic FAN_TWO_DRIVE_OUTPUT_OE
);
  ////////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] clip240(input logic [7:0] v);
    return (v > `FPD_FULL_DUTY) ? `FPD_FULL_DUTY : v;
  endfunction

  function automatic logic [7:0] auto_duty(input logic [7:0] temp, input logic [7:0] thr,
                                           input logic [7:0] sduty, input logic [3:0] step,
                                           input logic two_deg, input logic hold);
    logic [7:0] diff;
    logic [4:0] inc;
    logic [12:0] prod;
    logic [13:0] sum;
    diff = temp - thr;
    if (two_deg) begin
      diff = diff >> 1;
    end
    inc = (step == 4'hf) ? 5'h1f : {step, 1'b0};
    prod = diff * inc;
    sum = {6'h00, clip240(sduty)} + {1'b0, prod};
    if (temp < thr) begin
      return hold ? clip240(sduty) : 8'h00;
    end
    return (sum > 14'(`FPD_FULL_DUTY)) ? `FPD_FULL_DUTY : sum[7:0];
  endfunction

  function automatic fpd_state_t rst_state();
    fpd_state_t s;
    s = '0;
    s.cfg = fpd_cfg_t'(`FPD_RST_CFG);
    s.start_duty = `FPD_RST_START;
    for (int i = 0; i < 2; i++) begin
      s.fan[i].ceil = `FPD_RST_CEIL;
      s.fan[i].goal = `FPD_RST_GOAL;
      s.fan[i].now = `FPD_RST_NOW;
    end
    return s;
  endfunction

  fpd_state_t st_q;
  fpd_state_t st_d;
  logic [1:0] auto_mode;
  logic [7:0] auto_val [2];
  logic [7:0] eff [2];
  logic [7:0] tgt [2];
  logic [15:0] div_max;

  ////////////////////////////////////////////////////////////////////////////////
  // per-fan duty derivation
  for (genvar g = 0; g < 2; g++) begin : g_fan
    logic [7:0] d1;
    logic [7:0] d2;
    logic [7:0] raw;
    logic [7:0] cap;
    assign d1 = FAN_CTL[g].sel_ch1 ? auto_duty(TEMP_CH1, START_TEMP_CH1, st_q.start_duty,
      FAN_CTL[g].step, TEMP_STEP_TWO, st_q.cfg.min_hold) : 8'h00;
    assign d2 = FAN_CTL[g].sel_ch2 ? auto_duty(TEMP_CH2, START_TEMP_CH2, st_q.start_duty,
      FAN_CTL[g].step, TEMP_STEP_TWO, st_q.cfg.min_hold) : 8'h00;
    assign raw = (d1 > d2) ? d1 : d2;
    assign cap = clip240(st_q.fan[g].ceil);
    assign auto_mode[g] = FAN_CTL[g].sel_ch1 | FAN_CTL[g].sel_ch2;
    assign auto_val[g] = (raw > cap) ? cap : raw;
    assign tgt[g] = auto_mode[g] ? auto_val[g] : clip240(st_q.fan[g].goal);
    assign eff[g] = FREQ_SEL[0] ? {st_q.fan[g].now[7:2], 2'b00} : st_q.fan[g].now;
  end

  // select a b c map to bits 2 1 0
  always_comb begin
    case (FREQ_SEL)
      3'h0: div_max = 16'(SLOT_20 - 1);
      3'h2: div_max = 16'(SLOT_33 - 1);
      3'h4: div_max = 16'(SLOT_50 - 1);
      3'h6: div_max = 16'(SLOT_100 - 1);
      default: div_max = 16'(SLOT_35K - 1);
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    logic [7:0] ivl;
    logic active;
    logic level;
    logic pol;
    ivl = 8'h00;
    active = 1'b0;
    level = 1'b0;
    pol = 1'b0;
    st_d = st_q;
    st_d.tick = 1'b0;
    if (st_q.tick_cnt >= 24'(TICK_CYCLES - 1)) begin
      st_d.tick_cnt = 24'h000000;
      st_d.tick = 1'b1;
    end else begin
      st_d.tick_cnt = st_q.tick_cnt + 24'h000001;
    end
    if (st_q.div_cnt >= div_max) begin
      st_d.div_cnt = 16'h0000;
      st_d.slot_cnt = (st_q.slot_cnt >= 8'(`FPD_SLOTS - 1)) ? 8'h00 : st_q.slot_cnt + 8'h01;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 16'h0001;
    end
    if (REG_WR) begin
      case (REG_ADDR)
        `FPD_ADDR_CFG: st_d.cfg = fpd_cfg_t'(REG_WDATA);
        `FPD_ADDR_START: st_d.start_duty = REG_WDATA;
        `FPD_ADDR_CEIL1: st_d.fan[0].ceil = REG_WDATA;
        `FPD_ADDR_CEIL2: st_d.fan[1].ceil = REG_WDATA;
        `FPD_ADDR_GOAL1: st_d.fan[0].goal = REG_WDATA;
        `FPD_ADDR_GOAL2: st_d.fan[1].goal = REG_WDATA;
        default: ;
      endcase
    end
    for (int i = 0; i < 2; i++) begin
      if (auto_mode[i] && !st_q.cfg.standby) begin
        st_d.fan[i].goal = auto_val[i];
      end
      ivl = 8'h01 << (FAN_CTL[i].rate - 3'h1);
      if (!st_q.cfg.standby) begin
        if (FAN_CTL[i].rate == 3'h0) begin
          st_d.fan[i].now = tgt[i];
          st_d.fan[i].ramp_cnt = 8'h00;
        end else if (st_q.tick) begin
          if (st_q.fan[i].ramp_cnt >= ivl - 8'h01) begin
            st_d.fan[i].ramp_cnt = 8'h00;
            if (st_q.fan[i].now < tgt[i]) begin
              st_d.fan[i].now = (tgt[i] - st_q.fan[i].now >= `FPD_RAMP_STEP) ?
                st_q.fan[i].now + `FPD_RAMP_STEP : tgt[i];
            end else if (st_q.fan[i].now > tgt[i]) begin
              st_d.fan[i].now = (st_q.fan[i].now - tgt[i] >= `FPD_RAMP_STEP) ?
                st_q.fan[i].now - `FPD_RAMP_STEP : tgt[i];
            end
          end else begin
            st_d.fan[i].ramp_cnt = st_q.fan[i].ramp_cnt + 8'h01;
          end
        end
      end
      pol = (i == 0) ? st_q.cfg.pol1 : st_q.cfg.pol2;
      active = st_q.slot_cnt < eff[i];
      level = active ? pol : ~pol;
      st_d.drv_oe[i] = !st_q.cfg.standby && !level;
    end
    case (REG_ADDR)
      `FPD_ADDR_CFG: st_d.rdata = st_q.cfg;
      `FPD_ADDR_START: st_d.rdata = st_q.start_duty;
      `FPD_ADDR_CEIL1: st_d.rdata = st_q.fan[0].ceil;
      `FPD_ADDR_CEIL2: st_d.rdata = st_q.fan[1].ceil;
      `FPD_ADDR_GOAL1: st_d.rdata = st_q.fan[0].goal;
      `FPD_ADDR_GOAL2: st_d.rdata = st_q.fan[1].goal;
      `FPD_ADDR_NOW1: st_d.rdata = eff[0];
      `FPD_ADDR_NOW2: st_d.rdata = eff[1];
      default: st_d.rdata = 8'h00;
    endcase
    if (REG_WR && REG_ADDR == `FPD_ADDR_CFG && REG_WDATA[`FPD_BIT_SOFT_RST]) begin
      st_d = rst_state();
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_q <= rst_state();
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  assign REG_RDATA = st_q.rdata;
  assign CONVERT_HALT = st_q.cfg.standby;
  assign BUS_TIMEOUT_EN = !st_q.cfg.tmo_dis;
  assign TEMP2_SRC_DIE = st_q.cfg.src_die;
  assign SPINUP_EN = !st_q.cfg.spin_dis;
  assign FAN_ONE_DRIVE_OUTPUT_O = 1'b0;
  assign FAN_ONE_DRIVE_OUTPUT_OE = st_q.drv_oe[0];
  assign FAN_TWO_DRIVE_OUTPUT_O = 1'b0;
  assign FAN_TWO_DRIVE_OUTPUT_OE = st_q.drv_oe[1];

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_standby_release: assert property (
    st_q.cfg.standby && $past(st_q.cfg.standby) |-> st_q.drv_oe == 2'b00)
    else $error("pwm pin driven in standby");

  a_soft_reset: assert property (
    REG_WR && REG_ADDR == `FPD_ADDR_CFG && REG_WDATA[`FPD_BIT_SOFT_RST] |=>
      st_q.cfg == fpd_cfg_t'(`FPD_RST_CFG) && st_q.start_duty == `FPD_RST_START &&
      st_q.fan[0].ceil == `FPD_RST_CEIL && st_q.fan[1].goal == `FPD_RST_GOAL)
    else $error("soft reset did not restore registers");

  a_full_pol_one: assert property (
    eff[0] == `FPD_FULL_DUTY && !st_q.cfg.standby |=> st_q.drv_oe[0] == !$past(st_q.cfg.pol1))
    else $error("fan one full-duty level wrong");

  a_full_pol_two: assert property (
    eff[1] == `FPD_FULL_DUTY && !st_q.cfg.standby |=> st_q.drv_oe[1] == !$past(st_q.cfg.pol2))
    else $error("fan two full-duty level wrong");

  a_duty_bound: assert property (
    st_q.fan[0].now <= `FPD_FULL_DUTY && st_q.fan[1].now <= `FPD_FULL_DUTY)
    else $error("duty beyond full");

  a_ceiling_cap: assert property (
    auto_mode[0] && !st_q.cfg.standby |=> st_q.fan[0].goal <= clip240($past(st_q.fan[0].ceil)))
    else $error("goal above ceiling");

  a_goal_update: assert property (
    auto_mode[1] && !st_q.cfg.standby && !REG_WR |=> st_q.fan[1].goal == $past(auto_val[1]))
    else $error("goal not updated in automatic mode");

  a_instant_change: assert property (
    FAN_CTL[0].rate == 3'h0 && !st_q.cfg.standby && !REG_WR |=> st_q.fan[0].now == $past(tgt[0]))
    else $error("zero rate did not jump to goal");

  a_ramp_step: assert property (
    FAN_CTL[0].rate != 3'h0 && !REG_WR |=>
      st_q.fan[0].now == $past(st_q.fan[0].now) ||
      st_q.fan[0].now == $past(tgt[0]) ||
      st_q.fan[0].now == $past(st_q.fan[0].now) + `FPD_RAMP_STEP ||
      st_q.fan[0].now == $past(st_q.fan[0].now) - `FPD_RAMP_STEP)
    else $error("ramp step not two");

  a_present_read: assert property (
    REG_ADDR == `FPD_ADDR_NOW2 |=> REG_RDATA == $past(eff[1]))
    else $error("present duty read mismatch");
endmodule

/* File: logic/fpd_defines.svh */
// offsets, field positions, reset values and timing counts of the fan duty block
`ifndef FPD_DEFINES_SVH
`define FPD_DEFINES_SVH
`define FPD_ADDR_CFG 8'h02
`define FPD_ADDR_START 8'h08
`define FPD_ADDR_CEIL1 8'h09
`define FPD_ADDR_CEIL2 8'h0a
`define FPD_ADDR_GOAL1 8'h0b
`define FPD_ADDR_GOAL2 8'h0c
`define FPD_ADDR_NOW1 8'h0d
`define FPD_ADDR_NOW2 8'h0e
`define FPD_BIT_STANDBY 7
`define FPD_BIT_SOFT_RST 6
`define FPD_BIT_TMO_DIS 5
`define FPD_BIT_POL1 4
`define FPD_BIT_POL2 3
`define FPD_BIT_MIN_HOLD 2
`define FPD_BIT_SRC_DIE 1
`define FPD_BIT_SPIN_DIS 0
`define FPD_RST_CFG 8'h18
`define FPD_RST_START 8'h60
`define FPD_RST_CEIL 8'hf0
`define FPD_RST_GOAL 8'h00
`define FPD_RST_NOW 8'h00
`define FPD_FULL_DUTY 8'hf0
`define FPD_RAMP_STEP 8'h02
`define FPD_SLOTS 240
`define FPD_CLK_HZ 250000000
`define FPD_TICK_US 62500
`define FPD_FREQ_20 20
`define FPD_FREQ_33 33
`define FPD_FREQ_50 50
`define FPD_FREQ_100 100
`define FPD_FREQ_35K 35000
`endif

/* File: logic/fpd_pkg.sv */
// types of the fan duty block
package fpd_pkg;
  typedef struct packed {
    logic standby;
    logic soft_rst;
    logic tmo_dis;
    logic pol1;
    logic pol2;
    logic min_hold;
    logic src_die;
    logic spin_dis;
  } fpd_cfg_t;

  typedef struct packed {
    logic sel_ch1;
    logic sel_ch2;
    logic [2:0] rate;
    logic [3:0] step;
  } fpd_fan_ctl_t;

  typedef struct packed {
    logic [7:0] ceil;
    logic [7:0] goal;
    logic [7:0] now;
    logic [7:0] ramp_cnt;
  } fpd_fan_t;

  typedef struct packed {
    fpd_cfg_t cfg;
    logic [7:0] start_duty;
    fpd_fan_t [1:0] fan;
    logic [23:0] tick_cnt;
    logic tick;
    logic [15:0] div_cnt;
    logic [7:0] slot_cnt;
    logic [1:0] drv_oe;
    logic [7:0] rdata;
  } fpd_state_t;
endpackage

/* File: dv/fpd_fan_model.sv */
// open-drain fan input with a pull-up, as seen by the controller
`timescale 1ns/1ns
module fpd_fan_model (
  input logic drive_o,
  input logic drive_oe,
  output logic pin_level
);
  // a released line is pulled high by the fan input
  assign pin_level = drive_oe ? drive_o : 1'b1;
endmodule

/* File: dv/tb_fan_pwm_duty_control.sv */
// self-checking bench of the fan duty block against a behavioural duty model
`timescale 1ns/1ns
`include "fpd_defines.svh"
module tb_fan_pwm_duty_control import fpd_pkg::*;;
  logic clk = 0;
  logic rst = 1;
  logic wr = 0;
  logic tst = 0;
  logic [7:0] adr = 0, wd = 0, t1 = 0, t2 = 0, s1 = 0, s2 = 0, rdat;
  fpd_fan_ctl_t [1:0] fc = '0;
  logic [2:0] fs = 0;
  logic halt, tmo, die, spin, p1, p2, o1, o2, e1, e2;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  logic [7:0] ra[9] = '{8'h02, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h31};
  logic [7:0] rv[9] = '{8'h18, 8'h60, 8'hf0, 8'hf0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] wa[5] = '{8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  // frequency selects and their slot lengths in clock cycles
  logic [2:0] fm[5] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h1};
  int sl[5] = '{2, 3, 4, 5, `FPD_CLK_HZ / (`FPD_FREQ_35K * `FPD_SLOTS)};

  always #2 clk = ~clk;

  fpd_top #(.TICK_CYCLES(20), .SLOT_20(2), .SLOT_33(3), .SLOT_50(4), .SLOT_100(5)) uut (
    .CLK(clk), .RST(rst), .REG_WR(wr), .REG_ADDR(adr), .REG_WDATA(wd), .REG_RDATA(rdat),
    .TEMP_CH1(t1), .TEMP_CH2(t2), .START_TEMP_CH1(s1), .START_TEMP_CH2(s2),
    .TEMP_STEP_TWO(tst), .FAN_CTL(fc), .FREQ_SEL(fs), .CONVERT_HALT(halt),
    .BUS_TIMEOUT_EN(tmo), .TEMP2_SRC_DIE(die), .SPINUP_EN(spin),
    .FAN_ONE_DRIVE_OUTPUT_I(p1), .FAN_ONE_DRIVE_OUTPUT_O(o1), .FAN_ONE_DRIVE_OUTPUT_OE(e1),
    .FAN_TWO_DRIVE_OUTPUT_I(p2), .FAN_TWO_DRIVE_OUTPUT_O(o2), .FAN_TWO_DRIVE_OUTPUT_OE(e2));
  fpd_fan_model fan1 (.drive_o(o1), .drive_oe(e1), .pin_level(p1));
  fpd_fan_model fan2 (.drive_o(o2), .drive_oe(e2), .pin_level(p2));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    adr <= a;
    repeat (3) @(posedge clk);
    #1 d = rdat;
  endtask

  // expected automatic duty of one fan
  function automatic int ed(int t, int st, int sd, int c, int ts, int cl, int hold);
    int v;
    sd = (sd > 240) ? 240 : sd;
    v = (t < st) ? (hold ? sd : 0) : sd + ((t - st) / ts) * ((c == 15) ? 31 : 2 * c);
    v = (v > 240) ? 240 : v;
    return (v > cl) ? cl : v;
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] x;
    logic s;
    int q[$];
    int v[8];
    int e;
    void'($urandom(20));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i], d);
      chk(d, rv[i]);
    end
    repeat (4) begin
      x = 8'($urandom) & 8'hbf;
      wrr(8'h02, x);
      rd(8'h02, d);
      chk(d, x);
      chk({4'h0, halt, tmo, die, spin}, {4'h0, x[7], !x[5], x[1], !x[0]});
    end
    wrr(8'h09, 8'h33);
    wrr(8'h02, 8'h40);
    rd(8'h02, d);
    chk(d, 8'h18);
    rd(8'h09, d);
    chk(d, 8'hf0);
    // host writes start, ceiling and goal registers directly while no channel is assigned
    foreach (wa[i]) begin
      x = 8'($urandom) & 8'h7f;
      wrr(wa[i], x);
      q.push_back(x);
    end
    foreach (wa[i]) begin
      rd(wa[i], d);
      chk(d, 8'(q[i]));
    end
    wrr(8'h0d, 8'h55);
    rd(8'h0d, d);
    chk(d, 8'(q[3]));
    rd(8'h0e, d);
    chk(d, 8'(q[4]));
    wrr(8'h09, 8'h10);
    wrr(8'h0b, 8'hf9);
    rd(8'h0d, d);
    chk(d, 8'hf0);
    @(posedge clk);
    fs <= 3'b001;
    x = 8'($urandom % 241);
    wrr(8'h0b, x);
    rd(8'h0d, d);
    chk(d, x & 8'hfc);
    @(posedge clk);
    fs <= 3'b000;
    repeat (6) begin
      foreach (v[i]) v[i] = $urandom % 256;
      v[7] = v[7] % 239 + 2;
      @(posedge clk);
      t1 <= 8'(v[0]);
      t2 <= 8'(v[1]);
      s1 <= 8'(v[2]);
      s2 <= 8'(v[3]);
      tst <= v[4][0];
      fc[0] <= {2'b10, 3'h0, 4'(v[5])};
      fc[1] <= {2'b01, 3'h0, 4'(v[5])};
      wrr(8'h02, {5'h03, v[4][1], 2'h0});
      wrr(8'h08, 8'(v[6]));
      wrr(8'h09, 8'(v[7]));
      wrr(8'h0a, 8'(v[7]));
      for (int f = 0; f < 2; f++) begin
        e = ed(v[f], v[f + 2], v[6], v[5] % 16, v[4][0] + 1, v[7], v[4][1]);
        rd(8'h0b + 8'(f), d);
        chk(d, 8'(e));
        rd(8'h0d + 8'(f), d);
        chk(d, 8'(e));
      end
    end
    @(posedge clk);
    fc <= '0;
    wrr(8'h0b, 8'h00);
    @(posedge clk);
    fc[0] <= {2'b00, 3'h1, 4'h0};
    wrr(8'h0b, 8'h0a);
    rd(8'h0d, d);
    chk(8'(d <= 8'h02), 8'h01);
    repeat (150) @(posedge clk);
    rd(8'h0d, d);
    chk(d, 8'h0a);
    @(posedge clk);
    fc <= '0;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 2; k++) begin
        wrr(8'h02, {3'h0, 1'(p), 1'(p), 3'h0});
        wrr(8'h0b, k ? 8'hf0 : 8'h00);
        wrr(8'h0c, k ? 8'hf0 : 8'h00);
        repeat (10) @(posedge clk);
        s = 0;
        repeat (800) begin
          @(posedge clk);
          #1 s = s | (p1 !== 1'(p ~^ k)) | (p2 !== 1'(p ~^ k));
        end
        chk({7'h0, s}, 8'h00);
      end
    end
    // one full period per frequency select: active slots must equal the duty
    foreach (fm[i]) begin
      x = 8'($urandom % 241);
      @(posedge clk);
      fs <= fm[i];
      wrr(8'h0b, x);
      repeat (40) @(posedge clk);
      e = 0;
      repeat (`FPD_SLOTS * sl[i]) begin
        @(posedge clk);
        #1 e += (p1 === 1'b1);
      end
      chk(8'(e / sl[i]), fm[i][0] ? (x & 8'hfc) : x);
      chk(8'(e % sl[i]), 8'h00);
    end
    wrr(8'h02, 8'h80);
    s = 0;
    repeat (800) begin
      @(posedge clk);
      #1 s = s | (p1 !== 1'b1) | (p2 !== 1'b1) | (halt !== 1'b1);
    end
    chk({7'h0, s}, 8'h00);
    finish_test();
  end
endmodule
